// File: dgp_port_top.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dgp_params.svh"
// How it works
// - enabled peripheral takes over its pin
// - bank a has five output latch bits
// - pin four open drain, timer clock in
// - direction one floats, zero drives latch
// - bank a reads pins, writes latches
// - writes merge sampled pins into latches
// - comparator input pins read as zero
// - reset: inputs, digital off, inputs grounded
// - direction still governs comparator input pins
// - comparator outputs drive pins three, four
// - unimplemented bits read as zero
// - bank b eight bit bidirectional port
// - clear pull-up disable enables pull-ups
// - output pins lose their pull-up
// - pull-ups off after power-on reset
// - only upper four input pins compared
// - mismatches ORed into change flag
// - change event wakes device from sleep
// - any bank b access refreshes copy
// - mismatch keeps setting the flag
// - change at read instant may be missed
// - change flag sticky until cleared
// - enable gates request, flag still sets
module dgp_port_top
	import dgp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic [7:0]      regRdata,
	input  wire logic [4:0] bankAPinIn,
	output logic [4:0]      bankAPinOut,
	output logic [4:0]      bankAPinOe,
	output logic            groundCmpInputs,
	output logic            vrefOnPin,
	input  wire logic [7:0] bankBPinIn,
	output logic [7:0]      bankBPinOut,
	output logic [7:0]      bankBPinOe,
	output logic [7:0]      bankBPullupEn,
	input  wire logic [1:0] cmpResult,
	output logic            timerExtClockIn,
	output logic            portChangeIrq,
	output logic            wakeFromSleep
);
	////////////////////////////////////////////////////////////////////
	// state
	dgp_phase_t  phase_q;      // instruction cycle quarter
	logic [4:0]  latchA_q;     // bank a output latches
	logic [4:0]  dirA_q;       // bank a direction
	logic [7:0]  latchB_q;     // bank b output latches
	logic [7:0]  dirB_q;       // bank b direction
	logic [7:0]  option_q;     // option register
	logic [7:0]  cmpCtrl_q;    // comparator control
	logic [7:0]  vrefCtrl_q;   // voltage reference control
	logic        changeFlag_q; // port change flag
	logic        changeEn_q;   // port change enable
	logic [4:0]  pinA_q;       // sampled bank a pins
	logic [7:0]  pinB_q;       // sampled bank b pins
	logic        digitalOn_q;  // digital inputs enabled
	logic [3:0]  mismatch;     // per pin compare result
	logic        anyMismatch;  // ORed compare
	logic        sampleEn;     // once per instruction cycle
	logic [4:0]  cmpInMask;    // pins used as comparator inputs
	logic [4:0]  readA;        // bank a read value
	logic [4:0]  outA_d;       // bank a pad value
	logic [4:0]  oeA_d;        // bank a pad enable
	logic        accB;         // any bank b access
	logic [2:0]  cmpMode;      // comparator mode field

	assign cmpMode = cmpCtrl_q[2:0];
	assign accB    = (regWr || regRd) && (regAddr == `DGP_OFS_BANK_B_DATA);

	////////////////////////////////////////////////////////////////////
	// instruction cycle phase counter
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_q <= DGP_PH1;
		end else begin
			phase_q <= dgp_phase_t'(phase_q + 2'h1);
		end
	end
	assign sampleEn = (phase_q == DGP_PH1);

	////////////////////////////////////////////////////////////////////
	// registered input stage, once per instruction cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pinA_q <= 5'h00;
			pinB_q <= 8'h00;
		end else if (sampleEn) begin
			pinA_q <= bankAPinIn;
			pinB_q <= bankBPinIn;
		end
	end

	////////////////////////////////////////////////////////////////////
	// comparator input pins per mode, pins zero to three in modes 0-4, fewer in 5 and 6, none in mode 7
	always_comb begin
		unique case (cmpMode)
			3'h0, 3'h1, 3'h2, 3'h3, 3'h4: cmpInMask = 5'h0f;
			3'h5:                         cmpInMask = 5'h0a;
			3'h6:                         cmpInMask = 5'h07;
			3'h7:                         cmpInMask = 5'h00;
		endcase
	end

	// gated digital reads, comparator inputs read zero
	assign readA = digitalOn_q ? (pinA_q & ~cmpInMask) : 5'h00;

	////////////////////////////////////////////////////////////////////
	// digital input enable follows comparator mode, off at reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			digitalOn_q <= 1'b0;
		end else begin
			digitalOn_q <= (cmpMode != 3'h0);
		end
	end

	////////////////////////////////////////////////////////////////////
	// bank a latches, read-modify-write with sampled pins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latchA_q <= 5'h00;
		end else if (regWr && regAddr == `DGP_OFS_BANK_A_DATA) begin
			// inputs pick up sampled level, outputs take new data
			latchA_q <= (regWdata[4:0] & ~dirA_q) | (readA & dirA_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// bank b latches, read-modify-write with sampled pins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latchB_q <= 8'h00;
		end else if (regWr && regAddr == `DGP_OFS_BANK_B_DATA) begin
			latchB_q <= (regWdata & ~dirB_q) | (pinB_q & dirB_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dirA_q     <= `DGP_RST_BANK_A_DIR;
			dirB_q     <= `DGP_RST_BANK_B_DIR;
			option_q   <= `DGP_RST_OPTION;
			cmpCtrl_q  <= `DGP_RST_CMP_CTRL;
			vrefCtrl_q <= `DGP_RST_VREF_CTRL;
			changeEn_q <= 1'b0;
		end else if (regWr) begin
			unique case (regAddr)
				`DGP_OFS_BANK_A_DIR: dirA_q <= regWdata[4:0];
				`DGP_OFS_BANK_B_DIR: dirB_q <= regWdata;
				`DGP_OFS_OPTION:     option_q <= regWdata;
				`DGP_OFS_CMP_CTRL:   cmpCtrl_q <= regWdata & `DGP_CMP_CTRL_WMASK;
				`DGP_OFS_VREF_CTRL:  vrefCtrl_q <= regWdata & `DGP_VREF_CTRL_MASK;
				`DGP_OFS_INTCTL:     changeEn_q <= regWdata[`DGP_INT_CHANGE_EN_BIT];
				default: begin
					// other addresses leave configuration alone
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// change detection cells on upper four pins
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : gChange
			dgp_change_cell uCell (
				.clk_sys  (clk_sys),
				.rst      (rst),
				.sampleEn (sampleEn),
				.pinLevel (pinB_q[gi+4]),
				.isInput  (dirB_q[gi+4]),
				.snapEn   (accB),
				.mismatch (mismatch[gi])
			);
		end
	endgenerate
	assign anyMismatch = |mismatch;

	////////////////////////////////////////////////////////////////////
	// sticky change flag, set wins over software clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			changeFlag_q <= 1'b0;
		end else if (anyMismatch && !accB) begin
			changeFlag_q <= 1'b1;
		end else if (regWr && regAddr == `DGP_OFS_INTCTL) begin
			changeFlag_q <= regWdata[`DGP_INT_CHANGE_FLAG_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// register read port, data one cycle after strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			unique case (regAddr)
				`DGP_OFS_BANK_A_DATA: regRdata <= {3'h0, readA};
				`DGP_OFS_BANK_B_DATA: regRdata <= pinB_q;
				`DGP_OFS_BANK_A_DIR:  regRdata <= {3'h0, dirA_q};
				`DGP_OFS_BANK_B_DIR:  regRdata <= dirB_q;
				`DGP_OFS_OPTION:      regRdata <= option_q;
				`DGP_OFS_CMP_CTRL:    regRdata <= {cmpResult, cmpCtrl_q[5:0]};
				`DGP_OFS_VREF_CTRL:   regRdata <= vrefCtrl_q;
				`DGP_OFS_INTCTL:      regRdata <= {4'h0, changeEn_q, 2'h0, changeFlag_q};
				default:              regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// bank a pad drive: latch or comparator outputs, pin four open drain
	always_comb begin
		outA_d = latchA_q;
		oeA_d  = ~dirA_q;
		if (cmpMode == `DGP_CMP_MODE_OUTPUTS) begin
			outA_d[`DGP_BANK_A_PIN_THREE] = cmpResult[0];
			outA_d[`DGP_BANK_A_PIN_FOUR]  = cmpResult[1];
		end
		// open drain: only ever drive low
		oeA_d[`DGP_BANK_A_PIN_FOUR] = oeA_d[`DGP_BANK_A_PIN_FOUR]
			&& !outA_d[`DGP_BANK_A_PIN_FOUR];
		outA_d[`DGP_BANK_A_PIN_FOUR] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// registered pad outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bankAPinOut     <= 5'h00;
			bankAPinOe      <= 5'h00;
			groundCmpInputs <= 1'b1;
			vrefOnPin       <= 1'b0;
			bankBPinOut     <= 8'h00;
			bankBPinOe      <= 8'h00;
			bankBPullupEn   <= 8'h00;
			timerExtClockIn <= 1'b0;
			portChangeIrq   <= 1'b0;
			wakeFromSleep   <= 1'b0;
		end else begin
			bankAPinOut     <= outA_d;
			bankAPinOe      <= oeA_d;
			groundCmpInputs <= (cmpMode == 3'h0);
			vrefOnPin       <= vrefCtrl_q[7] && vrefCtrl_q[`DGP_VREF_OUT_EN_BIT];
			bankBPinOut     <= latchB_q;
			bankBPinOe      <= ~dirB_q;
			// global enable, then output pins drop pull-up
			bankBPullupEn   <= option_q[`DGP_OPT_PULLUP_DIS_BIT] ? 8'h00 : dirB_q;
			timerExtClockIn <= pinA_q[`DGP_BANK_A_PIN_FOUR];
			portChangeIrq   <= changeFlag_q && changeEn_q;
			wakeFromSleep   <= changeFlag_q && changeEn_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions
	// reset state of direction and pull-ups
	AST_RESET_DIR: assert property (@(posedge clk_sys) rst |=> dirA_q == 5'h1f)
		else $error("bank a direction not all inputs after reset");
	AST_PULLUP_OFF_POR: assert property (@(posedge clk_sys) rst |=> bankBPullupEn == 8'h00)
		else $error("pull-ups on after reset");
	// pull-ups: global enable, outputs always without
	AST_PULLUP_OUT: assert property (@(posedge clk_sys) disable iff (rst)
		##1 ((bankBPullupEn & ~$past(dirB_q)) == 8'h00))
		else $error("pull-up on an output pin");
	AST_PULLUP_GLOBAL: assert property (@(posedge clk_sys) disable iff (rst)
		!option_q[`DGP_OPT_PULLUP_DIS_BIT] |=> bankBPullupEn == $past(dirB_q))
		else $error("input pin lost its pull-up");
	// change flag behaviour
	AST_FLAG_STICKY: assert property (@(posedge clk_sys) disable iff (rst)
		changeFlag_q && !(regWr && regAddr == `DGP_OFS_INTCTL) |=> changeFlag_q)
		else $error("change flag dropped without clear");
	AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst)
		anyMismatch && !accB |=> changeFlag_q)
		else $error("mismatch did not set flag");
	AST_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (rst)
		!changeEn_q ##1 !changeEn_q |-> !portChangeIrq)
		else $error("irq without enable");
	// an access leaves no stale mismatch behind
	AST_SNAP_REFRESH: assert property (@(posedge clk_sys) disable iff (rst)
		accB && !sampleEn |=> !anyMismatch)
		else $error("access did not refresh compare copy");
	// pins only move on the sample cycle
	AST_SAMPLE_ONCE: assert property (@(posedge clk_sys) disable iff (rst)
		!sampleEn |=> $stable(pinB_q) && $stable(pinA_q))
		else $error("pins sampled off the sample cycle");
	// bank a pads and reads
	AST_PIN_FOUR_OD: assert property (@(posedge clk_sys) disable iff (rst)
		bankAPinOut[`DGP_BANK_A_PIN_FOUR] == 1'b0)
		else $error("pin four driven high");
	AST_A_READ_CMP: assert property (@(posedge clk_sys) disable iff (rst)
		regRd && regAddr == `DGP_OFS_BANK_A_DATA && cmpMode == 3'h2
		|=> regRdata[3:0] == 4'h0)
		else $error("comparator input read not zero");
	AST_A_READ_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		regRd && regAddr == `DGP_OFS_BANK_A_DATA && cmpMode == 3'h0 && $past(cmpMode) == 3'h0
		|=> regRdata == 8'h00)
		else $error("bank a read while digital inputs off");
	AST_GROUND_IN: assert property (@(posedge clk_sys) disable iff (rst)
		cmpMode == 3'h0 |=> groundCmpInputs)
		else $error("comparator inputs not grounded");
	AST_UNIMPL_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
		regRd && regAddr == `DGP_OFS_BANK_A_DIR |=> regRdata[7:5] == 3'h0)
		else $error("unimplemented bits not zero");
	AST_A_OE: assert property (@(posedge clk_sys) disable iff (rst)
		cmpMode != `DGP_CMP_MODE_OUTPUTS |=> bankAPinOe[3:0] == ~$past(dirA_q[3:0]))
		else $error("bank a enable not following direction");
	// read-modify-write: input latches take the sampled level
	AST_RMW_A: assert property (@(posedge clk_sys) disable iff (rst)
		regWr && regAddr == `DGP_OFS_BANK_A_DATA
		|=> ((latchA_q ^ $past(readA)) & $past(dirA_q)) == 5'h00)
		else $error("bank a input latch missed pin level");
	AST_RMW_B: assert property (@(posedge clk_sys) disable iff (rst)
		regWr && regAddr == `DGP_OFS_BANK_B_DATA
		|=> ((latchB_q ^ $past(pinB_q)) & $past(dirB_q)) == 8'h00)
		else $error("bank b input latch missed pin level");

	// main scenarios reached
	COV_FLAG: cover property (@(posedge clk_sys) disable iff (rst) $rose(changeFlag_q));
	COV_IRQ: cover property (@(posedge clk_sys) disable iff (rst) $rose(portChangeIrq));
	COV_WAKE: cover property (@(posedge clk_sys) disable iff (rst) $rose(wakeFromSleep));
	COV_CMPOUT: cover property (@(posedge clk_sys) disable iff (rst)
		cmpMode == `DGP_CMP_MODE_OUTPUTS);
endmodule
`default_nettype wire

// File: dgp_params.svh
`ifndef DGP_PARAMS_SVH
`define DGP_PARAMS_SVH

// register offsets on the plain register port
`define DGP_OFS_BANK_A_DATA  8'h05
`define DGP_OFS_BANK_B_DATA  8'h06
`define DGP_OFS_OPTION       8'h81
`define DGP_OFS_INTCTL       8'h0b
`define DGP_OFS_CMP_CTRL     8'h1f
`define DGP_OFS_BANK_A_DIR   8'h85
`define DGP_OFS_BANK_B_DIR   8'h86
`define DGP_OFS_VREF_CTRL    8'h9f

// reset values
`define DGP_RST_BANK_A_DIR   5'h1f
`define DGP_RST_BANK_B_DIR   8'hff
`define DGP_RST_OPTION       8'hff
`define DGP_RST_CMP_CTRL     8'h00
`define DGP_RST_VREF_CTRL    8'h00
`define DGP_RST_INTCTL       8'h00

// field positions
`define DGP_OPT_PULLUP_DIS_BIT   7
`define DGP_INT_CHANGE_FLAG_BIT  0
`define DGP_INT_CHANGE_EN_BIT    3
`define DGP_VREF_OUT_EN_BIT      6
`define DGP_BANK_A_PIN_TWO       2
`define DGP_BANK_A_PIN_THREE     3
`define DGP_BANK_A_PIN_FOUR      4

// masks of implemented bits
`define DGP_CMP_CTRL_MASK    8'hcf
`define DGP_CMP_CTRL_WMASK   8'h0f
`define DGP_VREF_CTRL_MASK   8'hef

// comparator mode codes that matter to the pins
`define DGP_CMP_MODE_OUTPUTS 3'h6
`define DGP_CMP_MODE_OFF     3'h7

// instruction cycle is four core clocks
`define DGP_CLKS_PER_INSTR   2'h3

`endif

// File: dgp_pkg.sv
package dgp_pkg;

	// one register port access
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dgp_bus_t;

	// one pin bank seen from the pads
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} dgp_pad_t;

	// quarter phases of the instruction cycle
	typedef enum logic [1:0] {
		DGP_PH1 = 2'b00,
		DGP_PH2 = 2'b01,
		DGP_PH3 = 2'b10,
		DGP_PH4 = 2'b11
	} dgp_phase_t;

endpackage

// File: dgp_change_cell.sv
`timescale 1ns/1ps
`default_nettype none
`include "dgp_params.svh"
module dgp_change_cell
	import dgp_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic sampleEn,
	input  wire logic pinLevel,
	input  wire logic isInput,
	input  wire logic snapEn,
	output logic      mismatch
);
	logic oldLevel_q;   // level latched at last port access

	////////////////////////////////////////////////////////////////////
	// refresh the comparison copy on each bank b access
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			oldLevel_q <= 1'b0;
		end else if (snapEn) begin
			oldLevel_q <= pinLevel;
		end
	end

	// outputs never compare, inputs compare against old copy
	assign mismatch = isInput && (pinLevel != oldLevel_q) && sampleEn;
endmodule
`default_nettype wire

// File: dgp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// board side of both pin banks: the device pads, the external drivers
// and whatever a released line does
module dgp_pin_model (
	input  wire logic       clk_sys,
	input  wire logic [4:0] bankAPinOut,
	input  wire logic [4:0] bankAPinOe,
	input  wire logic [7:0] bankBPinOut,
	input  wire logic [7:0] bankBPinOe,
	input  wire logic [7:0] bankBPullupEn,
	input  wire logic [4:0] extAVal,
	input  wire logic [4:0] extAEn,
	input  wire logic [7:0] extBVal,
	input  wire logic [7:0] extBEn,
	output logic [4:0]      bankAPinIn,
	output logic [7:0]      bankBPinIn
);
	logic floatQ;   // wandering level of an undriven line

	////////////////////////////////////////////////////////////////////////////
	// a floating line never holds its last value
	initial floatQ = 1'b0;
	always @(posedge clk_sys) begin
		floatQ <= ~floatQ;
	end

	////////////////////////////////////////////////////////////////////////////
	// pad wins, then the board driver, then pull-up on bank b only, else floating
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (bankAPinOe[i]) begin
				bankAPinIn[i] = bankAPinOut[i];
			end else if (extAEn[i]) begin
				bankAPinIn[i] = extAVal[i];
			end else begin
				bankAPinIn[i] = floatQ;
			end
		end
		for (int i = 0; i < 8; i++) begin
			if (bankBPinOe[i]) begin
				bankBPinIn[i] = bankBPinOut[i];
			end else if (extBEn[i]) begin
				bankBPinIn[i] = extBVal[i];
			end else if (bankBPullupEn[i]) begin
				bankBPinIn[i] = 1'b1;
			end else begin
				bankBPinIn[i] = floatQ ^ i[0];
			end
		end
	end
endmodule
`default_nettype wire

// File: dgp_port_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dgp_params.svh"
module dgp_port_top_bench;
	logic       clk_sys, rst;
	logic [7:0] regAddr, regWdata, regRdata;
	logic       regWr, regRd;
	logic [4:0] bankAPinIn, bankAPinOut, bankAPinOe, extAVal, extAEn;
	logic [7:0] bankBPinIn, bankBPinOut, bankBPinOe, bankBPullupEn, extBVal, extBEn;
	logic       groundCmpInputs, vrefOnPin, timerExtClockIn, portChangeIrq, wakeFromSleep;
	logic [1:0] cmpResult;
	logic [7:0] rv;
	int         miscompares, checkCount, cycles;
	// bank a read-back with all pins high, per comparator mode
	logic [7:0] aRead [8] = '{8'h00, 8'h10, 8'h10, 8'h10, 8'h10, 8'h15, 8'h18, 8'h1f};

	dgp_port_top i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.bankAPinIn(bankAPinIn), .bankAPinOut(bankAPinOut), .bankAPinOe(bankAPinOe),
		.groundCmpInputs(groundCmpInputs), .vrefOnPin(vrefOnPin),
		.bankBPinIn(bankBPinIn), .bankBPinOut(bankBPinOut), .bankBPinOe(bankBPinOe),
		.bankBPullupEn(bankBPullupEn), .cmpResult(cmpResult),
		.timerExtClockIn(timerExtClockIn), .portChangeIrq(portChangeIrq),
		.wakeFromSleep(wakeFromSleep));

	dgp_pin_model i_pins (.clk_sys(clk_sys), .bankAPinOut(bankAPinOut),
		.bankAPinOe(bankAPinOe), .bankBPinOut(bankBPinOut), .bankBPinOe(bankBPinOe),
		.bankBPullupEn(bankBPullupEn), .extAVal(extAVal), .extAEn(extAEn),
		.extBVal(extBVal), .extBEn(extBEn), .bankAPinIn(bankAPinIn),
		.bankBPinIn(bankBPinIn));

	////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// helpers: verdict, compare, bus cycles, settle
	task automatic test_done();
		if (miscompares == 0 && checkCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clk_sys);
		regWr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk_sys);
		regRd   <= 1'b0;
		#1 d = regRdata;   // data stands only in this cycle
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check(d, exp);
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'b1;
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		extAVal = 5'h1f;
		extAEn = 5'h1f;
		extBVal = 8'h00;
		extBEn = 8'hff;
		cmpResult = 2'b00;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		// reset values and unmapped place
		rdc(`DGP_OFS_BANK_A_DIR, 8'h1f);
		rdc(`DGP_OFS_BANK_B_DIR, 8'hff);
		rdc(`DGP_OFS_OPTION, 8'hff);
		rdc(`DGP_OFS_VREF_CTRL, 8'h00);
		rdc(`DGP_OFS_INTCTL, 8'h00);
		rdc(`DGP_OFS_BANK_A_DATA, 8'h00);
		rdc(8'h40, 8'h00);
		check({7'h0, groundCmpInputs}, 8'h01);
		check(bankBPullupEn, 8'h00);
		check({3'h0, bankAPinOe}, 8'h00);
		// comparator control: live result bits, unimplemented zero
		@(posedge clk_sys) cmpResult <= 2'b10;
		wr(`DGP_OFS_CMP_CTRL, 8'hf7);
		rdc(`DGP_OFS_CMP_CTRL, 8'h87);
		check({7'h0, groundCmpInputs}, 8'h00);
		// comparator input pins read as zero, modes one to seven
		for (int m = 1; m < 8; m++) begin
			wr(`DGP_OFS_CMP_CTRL, 8'(m));
			waitc(8);
			rdc(`DGP_OFS_BANK_A_DATA, aRead[m]);
		end
		// bank a drivers, open drain pin four
		wr(`DGP_OFS_BANK_A_DIR, 8'hff);
		rdc(`DGP_OFS_BANK_A_DIR, 8'h1f);
		wr(`DGP_OFS_BANK_A_DIR, 8'h00);
		wr(`DGP_OFS_BANK_A_DATA, 8'h1f);
		waitc(2);
		check({3'h0, bankAPinOut}, 8'h0f);
		check({3'h0, bankAPinOe}, 8'h0f);
		wr(`DGP_OFS_BANK_A_DATA, 8'h00);
		waitc(8);
		check({3'h0, bankAPinOe}, 8'h1f);
		rdc(`DGP_OFS_BANK_A_DATA, 8'h00);
		wr(`DGP_OFS_BANK_A_DIR, 8'h1f);
		waitc(2);
		check({3'h0, bankAPinOe}, 8'h00);
		// pin four as timer clock input
		@(posedge clk_sys) extAVal <= 5'h00;
		waitc(8);
		check({7'h0, timerExtClockIn}, 8'h00);
		@(posedge clk_sys) extAVal <= 5'h10;
		waitc(8);
		check({7'h0, timerExtClockIn}, 8'h01);
		rdc(`DGP_OFS_BANK_A_DATA, 8'h10);
		// comparator outputs take pins three and four
		wr(`DGP_OFS_BANK_A_DIR, 8'h07);
		wr(`DGP_OFS_CMP_CTRL, 8'h06);
		@(posedge clk_sys) cmpResult <= 2'b11;
		waitc(3);
		check({6'h0, bankAPinOe[4:3]}, 8'h01);
		check({7'h0, bankAPinOut[3]}, 8'h01);
		@(posedge clk_sys) cmpResult <= 2'b00;
		waitc(3);
		check({6'h0, bankAPinOe[4:3]}, 8'h03);
		check({7'h0, bankAPinOut[3]}, 8'h00);
		wr(`DGP_OFS_CMP_CTRL, 8'h07);
		wr(`DGP_OFS_BANK_A_DIR, 8'h1f);
		// reference output on pin two
		wr(`DGP_OFS_VREF_CTRL, 8'hff);
		rdc(`DGP_OFS_VREF_CTRL, 8'hef);
		check({7'h0, vrefOnPin}, 8'h01);
		wr(`DGP_OFS_VREF_CTRL, 8'h00);
		// bank b drivers and pull-ups
		wr(`DGP_OFS_BANK_B_DIR, 8'h00);
		wr(`DGP_OFS_BANK_B_DATA, 8'ha5);
		waitc(2);
		check(bankBPinOut, 8'ha5);
		check(bankBPinOe, 8'hff);
		wr(`DGP_OFS_BANK_B_DIR, 8'hf0);
		wr(`DGP_OFS_OPTION, 8'h7f);
		waitc(2);
		check(bankBPullupEn, 8'hf0);
		rdc(`DGP_OFS_OPTION, 8'h7f);
		wr(`DGP_OFS_BANK_B_DIR, 8'hff);
		@(posedge clk_sys) extBVal <= 8'h3c;
		waitc(8);
		rdc(`DGP_OFS_BANK_B_DATA, 8'h3c);
		// change detection on the upper pins
		@(posedge clk_sys) extBVal <= 8'h00;
		waitc(8);
		rd(`DGP_OFS_BANK_B_DATA, rv);
		wr(`DGP_OFS_INTCTL, 8'h08);
		@(posedge clk_sys) extBVal <= 8'h01;
		waitc(8);
		rdc(`DGP_OFS_INTCTL, 8'h08);
		@(posedge clk_sys) extBVal <= 8'h21;
		waitc(8);
		check({7'h0, portChangeIrq}, 8'h01);
		check({7'h0, wakeFromSleep}, 8'h01);
		rdc(`DGP_OFS_INTCTL, 8'h09);
		wr(`DGP_OFS_INTCTL, 8'h08);
		waitc(8);
		rdc(`DGP_OFS_INTCTL, 8'h09);
		rd(`DGP_OFS_BANK_B_DATA, rv);
		wr(`DGP_OFS_INTCTL, 8'h08);
		waitc(8);
		rdc(`DGP_OFS_INTCTL, 8'h08);
		check({7'h0, portChangeIrq}, 8'h00);
		// flag sets with the enable clear
		wr(`DGP_OFS_INTCTL, 8'h00);
		@(posedge clk_sys) extBVal <= 8'h41;
		waitc(8);
		check({7'h0, portChangeIrq}, 8'h00);
		rdc(`DGP_OFS_INTCTL, 8'h01);
		// an output pin changing is not compared
		wr(`DGP_OFS_BANK_B_DIR, 8'hdf);
		wr(`DGP_OFS_BANK_B_DATA, 8'h00);
		waitc(8);
		rd(`DGP_OFS_BANK_B_DATA, rv);
		wr(`DGP_OFS_INTCTL, 8'h00);
		wr(`DGP_OFS_BANK_B_DATA, 8'h20);
		waitc(8);
		check(bankBPinOut, 8'h61);
		rdc(`DGP_OFS_INTCTL, 8'h00);
		test_done();
	end
endmodule
`default_nettype wire
